// ---- inc/nnp_params.svh ----
// constants of the network node parameter register bank
`ifndef NNP_PARAMS_SVH
`define NNP_PARAMS_SVH
// register indexes; byte address is four times the index
`define NNP_IDX_NODE_NUMBER   12'ha8c
`define NNP_IDX_FLAG_OFFSET   12'ha8f
`define NNP_IDX_INPUT_OFFSET  12'ha90
`define NNP_IDX_OUTPUT_OFFSET 12'ha91
`define NNP_IDX_OUT_MASK      12'ha92
`define NNP_IDX_INDIRECT_NODE 12'ha93
`define NNP_IDX_TIMEOUT_MS    12'ha94
`define NNP_IDX_RESP_TIME_MS  12'ha95
`define NNP_IDX_ERROR_COUNT   12'ha96
`define NNP_IDX_LAST_ERROR    12'ha97
// reset values
`define NNP_RST_NODE_NUMBER   7'h02
`define NNP_RST_FLAG_OFFSET   16'h0000
`define NNP_RST_INPUT_OFFSET  16'h0064
`define NNP_RST_OUTPUT_OFFSET 16'h0064
`define NNP_RST_OUT_MASK      16'h0064
`define NNP_RST_INDIRECT_NODE 16'h0000
`define NNP_RST_TIMEOUT_MS    16'h00fa
`define NNP_RST_RESP_TIME_MS  16'h0000
`define NNP_RST_ERROR_COUNT   8'h00
`define NNP_RST_LAST_ERROR    16'h0000
// last error codes
`define NNP_ERR_NONE          16'h0000
`define NNP_ERR_TIMEOUT       16'h0001
`define NNP_ERR_CHECKSUM      16'h0002
`define NNP_ERR_SLAVE         16'h0003
`define NNP_ERR_NO_MASTER     16'h0004
// node roles
`define NNP_NODE_OFF          7'h00
`define NNP_NODE_MASTER       7'h01
// timing: clock period and one millisecond, both in ns
`define NNP_CLK_PERIOD_NS     20
`define NNP_MS_NS             1000000
`define NNP_MS_CYCLES         (`NNP_MS_NS / `NNP_CLK_PERIOD_NS)
`endif

// ---- inc/nnp_pkg.sv ----
// types of the network node parameter register bank
package nnp_pkg;
  // network role derived from the node number
  typedef enum logic [1:0] {NNP_OFF, NNP_MASTER, NNP_SLAVE} nnp_role_t;
  // kind of item a remote access names
  typedef enum logic [1:0] {NNP_FLAG, NNP_INPUT, NNP_OUTPUT} nnp_kind_t;
  // state of the access tracker
  typedef enum logic {NNP_IDLE, NNP_WAIT} nnp_fsm_t;
  // reply status from the link layer
  typedef enum logic [1:0] {NNP_OK, NNP_CKSUM, NNP_SLVERR} nnp_stat_t;
  // whole state of the bank
  typedef struct packed {
    logic [6:0]  node;
    logic [15:0] flag_off;
    logic [15:0] in_off;
    logic [15:0] out_off;
    logic [15:0] mask;
    logic [15:0] indirect;
    logic [15:0] timeout;
    logic [15:0] resp_time;
    logic [7:0]  err_cnt;
    logic [15:0] last_err;
    logic        wr_pend;
    logic [11:0] wr_idx;
    logic [31:0] hrdata;
    logic        hready;
    logic [16:0] res_num;
    logic        res_vld;
    logic [15:0] outs;
    logic [6:0]  target;
    nnp_role_t   role;
    nnp_fsm_t    fsm;
    logic [31:0] ms_cnt;
    logic [15:0] elapsed;
  } nnp_st_t;
endpackage

// ---- hw/nnp_regs.sv ----
// network node parameter register bank with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "nnp_params.svh"
module nnp_regs
  import nnp_pkg::*;
#(
  parameter int MS_CYCLES = `NNP_MS_CYCLES  // clock cycles in one ms
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // remote item access
  input  wire logic        remote_req,
  input  wire logic        remote_ext,
  input  wire nnp_kind_t   remote_kind,
  input  wire logic [15:0] remote_num,
  output logic [16:0]      resolved_num,
  output logic             resolved_vld,
  // outputs 101-108 and 201-208
  input  wire logic        local_out_we,
  input  wire logic [15:0] local_out_val,
  input  wire logic        remote_scan_we,
  input  wire logic [15:0] remote_scan_val,
  output logic [15:0]      out_state,
  // network instruction target
  input  wire logic [6:0]  instr_node,
  output logic [6:0]       target_node,
  output nnp_role_t        node_role,
  // access tracking events
  input  wire logic        net_req_sent,
  input  wire logic        net_reply,
  input  wire nnp_stat_t   net_reply_stat,
  input  wire logic        net_no_master
);

  nnp_st_t s_q;  // registered state
  nnp_st_t s_d;  // next state
  logic    addr_ok;  // valid address phase
  logic [11:0] idx;  // word index of the access
  logic    ms_tick;  // one pulse per ms while waiting
  logic    hw_err;  // hardware reports an error this cycle
  logic [15:0] hw_code;  // code that goes with it

  assign addr_ok = hsel & htrans[1] & hready;
  assign idx     = haddr[13:2];
  assign ms_tick = (s_q.ms_cnt == 32'(MS_CYCLES - 1));

  // next state: bus, offsets, outputs and tracker
  always_comb begin
    s_d = s_q;
    hw_err = 1'b0;
    hw_code = `NNP_ERR_NONE;
    s_d.hready = 1'b1;
    // data phase of a write lands here; reads never stall
    if (s_q.wr_pend) begin
      if (s_q.wr_idx == `NNP_IDX_NODE_NUMBER) begin
        s_d.node = hwdata[6:0];
      end else if (s_q.wr_idx == `NNP_IDX_FLAG_OFFSET) begin
        s_d.flag_off = hwdata[15:0];
      end else if (s_q.wr_idx == `NNP_IDX_INPUT_OFFSET) begin
        s_d.in_off = hwdata[15:0];
      end else if (s_q.wr_idx == `NNP_IDX_OUTPUT_OFFSET) begin
        s_d.out_off = hwdata[15:0];
      end else if (s_q.wr_idx == `NNP_IDX_OUT_MASK) begin
        s_d.mask = hwdata[15:0];
      end else if (s_q.wr_idx == `NNP_IDX_INDIRECT_NODE) begin
        s_d.indirect = hwdata[15:0];
      end else if (s_q.wr_idx == `NNP_IDX_TIMEOUT_MS) begin
        s_d.timeout = hwdata[15:0];
      end else if (s_q.wr_idx == `NNP_IDX_LAST_ERROR) begin
        s_d.last_err = hwdata[15:0];
      end
      // response time and error count ignore writes
    end
    s_d.wr_pend = addr_ok & hwrite;
    if (addr_ok) begin
      s_d.wr_idx = idx;
    end
    s_d.res_vld = remote_req;
    if (remote_req) begin
      if (!remote_ext) begin
        s_d.res_num = {1'b0, remote_num};
      end else if (remote_kind == NNP_FLAG) begin
        s_d.res_num = {1'b0, remote_num} + {1'b0, s_q.flag_off};
      end else if (remote_kind == NNP_INPUT) begin
        s_d.res_num = {1'b0, remote_num} + {1'b0, s_q.in_off};
      end else begin
        s_d.res_num = {1'b0, remote_num} + {1'b0, s_q.out_off};
      end
    end
    // bit i of outs and mask is the same output
    if (local_out_we) begin
      s_d.outs = local_out_val;
    end else if (remote_scan_we) begin
      s_d.outs = (s_q.outs & s_q.mask) | (remote_scan_val & ~s_q.mask);
    end
    // extended output access toggles any bit, mask bypassed
    if (remote_req && remote_ext && remote_kind == NNP_OUTPUT &&
        remote_num[15:4] == 12'h000) begin
      s_d.outs[remote_num[3:0]] = ~s_q.outs[remote_num[3:0]];
    end
    // node 0 picks the indirect node
    s_d.target = (instr_node == 7'h00) ? s_q.indirect[6:0] : instr_node;
    if (s_d.node == `NNP_NODE_OFF) begin
      s_d.role = NNP_OFF;
    end else if (s_d.node == `NNP_NODE_MASTER) begin
      s_d.role = NNP_MASTER;
    end else begin
      s_d.role = NNP_SLAVE;
    end
    // millisecond timebase, runs only while waiting
    s_d.ms_cnt = (ms_tick || s_q.fsm == NNP_IDLE) ? 32'h0 : s_q.ms_cnt + 32'h1;
    case (s_q.fsm)
      NNP_IDLE: begin
        if (net_req_sent) begin
          s_d.fsm = NNP_WAIT;
          s_d.elapsed = 16'h0000;
        end
      end
      NNP_WAIT: begin
        if (ms_tick && s_q.elapsed != 16'hffff) begin
          s_d.elapsed = s_q.elapsed + 16'h0001;
        end
        if (net_reply) begin
          s_d.resp_time = s_q.elapsed;
          s_d.fsm = NNP_IDLE;
          if (net_reply_stat == NNP_CKSUM) begin
            hw_err = 1'b1;
            hw_code = `NNP_ERR_CHECKSUM;
          end else if (net_reply_stat == NNP_SLVERR) begin
            hw_err = 1'b1;
            hw_code = `NNP_ERR_SLAVE;
          end else begin
            s_d.last_err = `NNP_ERR_NONE;
          end
        end else if (s_q.elapsed >= s_q.timeout) begin
          s_d.fsm = NNP_IDLE;
          hw_err = 1'b1;
          hw_code = `NNP_ERR_TIMEOUT;
        end
      end
      default: begin
        s_d.fsm = NNP_IDLE;
      end
    endcase
    // missing master has its own code
    if (net_no_master) begin
      hw_err = 1'b1;
      hw_code = `NNP_ERR_NO_MASTER;
    end
    // hardware event wins over a software write in the same cycle
    if (hw_err) begin
      s_d.last_err = hw_code;
      if (s_q.err_cnt != 8'hff) begin
        s_d.err_cnt = s_q.err_cnt + 8'h01;
      end
    end
    // read data from next values so write-then-read sees new data
    s_d.hrdata = 32'h0;
    if (addr_ok && !hwrite) begin
      if (idx == `NNP_IDX_NODE_NUMBER) begin
        s_d.hrdata = {25'h0, s_d.node};
      end else if (idx == `NNP_IDX_FLAG_OFFSET) begin
        s_d.hrdata = {16'h0, s_d.flag_off};
      end else if (idx == `NNP_IDX_INPUT_OFFSET) begin
        s_d.hrdata = {16'h0, s_d.in_off};
      end else if (idx == `NNP_IDX_OUTPUT_OFFSET) begin
        s_d.hrdata = {16'h0, s_d.out_off};
      end else if (idx == `NNP_IDX_OUT_MASK) begin
        s_d.hrdata = {16'h0, s_d.mask};
      end else if (idx == `NNP_IDX_INDIRECT_NODE) begin
        s_d.hrdata = {16'h0, s_d.indirect};
      end else if (idx == `NNP_IDX_TIMEOUT_MS) begin
        s_d.hrdata = {16'h0, s_d.timeout};
      end else if (idx == `NNP_IDX_RESP_TIME_MS) begin
        s_d.hrdata = {16'h0, s_d.resp_time};
      end else if (idx == `NNP_IDX_ERROR_COUNT) begin
        s_d.hrdata = {24'h0, s_d.err_cnt};
      end else if (idx == `NNP_IDX_LAST_ERROR) begin
        s_d.hrdata = {16'h0, s_d.last_err};
      end
      // unmapped reads return zero with OKAY
    end
  end

  // state register; reset puts every field at its documented value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.node <= `NNP_RST_NODE_NUMBER;
      s_q.flag_off <= `NNP_RST_FLAG_OFFSET;
      s_q.in_off <= `NNP_RST_INPUT_OFFSET;
      s_q.out_off <= `NNP_RST_OUTPUT_OFFSET;
      s_q.mask <= `NNP_RST_OUT_MASK;
      s_q.indirect <= `NNP_RST_INDIRECT_NODE;
      s_q.timeout <= `NNP_RST_TIMEOUT_MS;
      s_q.resp_time <= `NNP_RST_RESP_TIME_MS;
      s_q.err_cnt <= `NNP_RST_ERROR_COUNT;
      s_q.last_err <= `NNP_RST_LAST_ERROR;
      s_q.role <= NNP_SLAVE;
      s_q.fsm <= NNP_IDLE;
      // bus stays ready through reset so the first transfer never stalls
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout    = s_q.hready;
  assign hrdata       = s_q.hrdata;
  assign hresp        = 1'b0;
  assign resolved_num = s_q.res_num;
  assign resolved_vld = s_q.res_vld;
  assign out_state    = s_q.outs;
  assign target_node  = s_q.target;
  assign node_role    = s_q.role;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_resolve_flag;
    remote_req && remote_ext && remote_kind == NNP_FLAG
      |=> resolved_vld && resolved_num == $past(remote_num) + $past(s_q.flag_off);
  endproperty
  a_resolve_flag: assert property (p_resolve_flag)
    else $error("flag offset not added");

  property p_reset_offsets;
    $past(rst) |-> s_q.in_off == 16'h0064 && s_q.out_off == 16'h0064
      && s_q.flag_off == 16'h0000;
  endproperty
  a_reset_offsets: assert property (p_reset_offsets)
    else $error("offset reset value wrong");

  property p_mask_hold;
    remote_scan_we && !local_out_we && !remote_req
      |=> (out_state & $past(s_q.mask)) == ($past(out_state) & $past(s_q.mask));
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("masked output changed by scan");

  property p_indirect;
    instr_node == 7'h00 |=> target_node == $past(s_q.indirect[6:0]);
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect node not used");

  property p_timeout;
    s_q.fsm == NNP_WAIT && s_q.elapsed >= s_q.timeout && !net_reply && !net_no_master
      |=> s_q.last_err == 16'h0001 && s_q.fsm == NNP_IDLE;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("time-out not recorded");

  property p_cnt_mono;
    s_q.err_cnt >= $past(s_q.err_cnt);
  endproperty
  a_cnt_mono: assert property (p_cnt_mono)
    else $error("error count decreased");

  property p_resp_time;
    s_q.fsm == NNP_WAIT && net_reply |=> s_q.resp_time == $past(s_q.elapsed);
  endproperty
  a_resp_time: assert property (p_resp_time)
    else $error("response time not stored");

  property p_role;
    ##1 (s_q.node == 7'h01) |-> node_role == NNP_MASTER;
  endproperty
  a_role: assert property (p_role)
    else $error("role does not follow node");

  property p_sw_err;
    s_q.wr_pend && s_q.wr_idx == `NNP_IDX_LAST_ERROR && !net_no_master
      && !(s_q.fsm == NNP_WAIT && (net_reply || s_q.elapsed >= s_q.timeout))
      |=> s_q.last_err == $past(hwdata[15:0]);
  endproperty
  a_sw_err: assert property (p_sw_err)
    else $error("last error write lost");

  c_timeout: cover property (s_q.fsm == NNP_WAIT ##1 s_q.last_err == 16'h0001);
  c_reply: cover property (net_req_sent ##[1:20] net_reply);
  c_mask: cover property (remote_scan_we && s_q.mask != 16'h0000);
endmodule
`default_nettype wire

// ---- verif/nnp_net_partner.sv ----
// far-side network node model: answers a request after a set delay
`timescale 1ns/1ps
`default_nettype none
module nnp_net_partner
  import nnp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic       answer,
  input  wire logic [7:0] dly,
  input  wire nnp_stat_t  stat_sel,
  output logic            net_req_sent,
  output logic            net_reply,
  output var nnp_stat_t   net_reply_stat
);
  logic       busy;  // a request is outstanding
  logic [7:0] cnt;   // cycles left before the reply
  logic       tick;  // toggles so an idle status never looks stable
  // one request at a time; silence models a dead slave for time-outs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      tick <= 1'b0;
      net_req_sent <= 1'b0;
      net_reply <= 1'b0;
      net_reply_stat <= NNP_OK;
    end else begin
      tick <= ~tick;
      net_req_sent <= 1'b0;
      net_reply <= 1'b0;
      // status is only meaningful with the reply strobe
      net_reply_stat <= nnp_stat_t'({1'b0, tick});
      if (go && !busy) begin
        net_req_sent <= 1'b1;
        busy <= 1'b1;
        cnt <= dly;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        net_reply <= answer;
        if (answer) begin
          net_reply_stat <= stat_sel;
        end
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/nnp_regs_tb.sv ----
// self-checking bench of the network node parameter register bank
`timescale 1ns/1ps
`default_nettype none
`include "nnp_params.svh"
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module nnp_regs_tb
  import nnp_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic remote_req = 1'b0, remote_ext = 1'b0, resolved_vld;
  nnp_kind_t remote_kind = NNP_FLAG;
  logic [15:0] remote_num = 16'h0, local_out_val = 16'h0, remote_scan_val = 16'h0, out_state;
  logic local_out_we = 1'b0, remote_scan_we = 1'b0, net_no_master = 1'b0;
  logic [16:0] resolved_num;
  logic [6:0] instr_node = 7'h02, target_node;
  nnp_role_t node_role;
  logic net_req_sent, net_reply, go = 1'b0, answer = 1'b0;
  logic [7:0] dly = 8'h00;
  nnp_stat_t net_reply_stat, pstat = NNP_OK;
  int num_errors = 0, checks_done = 0, cyc = 0;
  always #10 mclk = ~mclk;
  // short millisecond so time-outs fit in a short run
  nnp_regs #(.MS_CYCLES(4)) u_dut (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .remote_req(remote_req),
    .remote_ext(remote_ext), .remote_kind(remote_kind), .remote_num(remote_num),
    .resolved_num(resolved_num), .resolved_vld(resolved_vld), .local_out_we(local_out_we),
    .local_out_val(local_out_val), .remote_scan_we(remote_scan_we),
    .remote_scan_val(remote_scan_val), .out_state(out_state), .instr_node(instr_node),
    .target_node(target_node), .node_role(node_role), .net_req_sent(net_req_sent),
    .net_reply(net_reply), .net_reply_stat(net_reply_stat), .net_no_master(net_no_master));
  nnp_net_partner u_far (.mclk(mclk), .rst(rst), .go(go), .answer(answer), .dly(dly),
    .stat_sel(pstat), .net_req_sent(net_req_sent), .net_reply(net_reply),
    .net_reply_stat(net_reply_stat));
  // verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard: the whole run needs under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results;
    end
  end
  // one ahb-lite single word transfer; data sampled just before the closing edge
  task automatic xfer(input logic wr, input logic [11:0] i, input logic [31:0] d,
                      output logic [31:0] q);
    logic r;
    @(posedge mclk);
    htrans <= 2'b10; hwrite <= wr; haddr <= {18'h0, i, 2'b00};
    do begin @(negedge mclk); r = hreadyout; @(posedge mclk); end while (r !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do begin @(negedge mclk); r = hreadyout; q = hrdata; @(posedge mclk); end while (r !== 1'b1);
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [11:0] i, output logic [31:0] q);
    xfer(1'b0, i, 32'h0, q);
  endtask
  // one-cycle pulse helpers; remote and outs return at the negedge after the taking edge
  task automatic remote(input logic e, input nnp_kind_t k, input logic [15:0] n);
    @(posedge mclk);
    remote_req <= 1'b1; remote_ext <= e; remote_kind <= k; remote_num <= n;
    @(posedge mclk); remote_req <= 1'b0; @(negedge mclk);
  endtask
  task automatic outs(input logic lw, input logic [15:0] lv, input logic sw, input logic [15:0] sv);
    @(posedge mclk);
    local_out_we <= lw; local_out_val <= lv; remote_scan_we <= sw; remote_scan_val <= sv;
    @(posedge mclk); local_out_we <= 1'b0; remote_scan_we <= 1'b0; @(negedge mclk);
  endtask
  task automatic net(input logic a, input logic [7:0] d, input nnp_stat_t s, input int w);
    @(posedge mclk); go <= 1'b1; answer <= a; dly <= d; pstat <= s;
    @(posedge mclk); go <= 1'b0; repeat (w) @(posedge mclk);
  endtask
  task automatic t_reset;
    logic [11:0] ix[10] = '{`NNP_IDX_NODE_NUMBER, `NNP_IDX_FLAG_OFFSET, `NNP_IDX_INPUT_OFFSET,
      `NNP_IDX_OUTPUT_OFFSET, `NNP_IDX_OUT_MASK, `NNP_IDX_INDIRECT_NODE, `NNP_IDX_TIMEOUT_MS,
      `NNP_IDX_RESP_TIME_MS, `NNP_IDX_ERROR_COUNT, `NNP_IDX_LAST_ERROR};
    logic [31:0] ex[10] = '{32'h2, 32'h0, 32'h64, 32'h64, 32'h64, 32'h0, 32'hfa, 32'h0, 32'h0, 32'h0};
    logic [31:0] q;
    `CHK(node_role, NNP_SLAVE)
    for (int i = 0; i < 10; i++) begin
      rd(ix[i], q);
      `CHK(q, ex[i])
    end
    // unmapped places read zero
    rd(12'h0ff, q);
    `CHK(q, 32'h0)
    // bus is always ready and always answers okay
    `CHK({hreadyout, hresp}, 2'b10)
    $display("test reset values done");
  endtask
  task automatic t_rw;
    logic [31:0] q;
    for (int i = 0; i < 3; i++) begin
      wr(`NNP_IDX_FLAG_OFFSET + 12'(i), 32'hffffffff);
      rd(`NNP_IDX_FLAG_OFFSET + 12'(i), q);
      `CHK(q, 32'h0000ffff)
    end
    wr(`NNP_IDX_TIMEOUT_MS, 32'h3);
    rd(`NNP_IDX_TIMEOUT_MS, q);
    `CHK(q, 32'h3)
    $display("test read write done");
  endtask
  task automatic t_resolve;
    nnp_kind_t k[3] = '{NNP_FLAG, NNP_INPUT, NNP_OUTPUT};
    logic [16:0] ex[3] = '{17'h10006, 17'h1fffe, 17'h10063};
    wr(`NNP_IDX_FLAG_OFFSET, 32'h7);
    wr(`NNP_IDX_OUTPUT_OFFSET, 32'h64);
    for (int i = 0; i < 3; i++) begin
      remote(1'b1, k[i], 16'hffff);
      `CHK({resolved_vld, resolved_num}, {1'b1, ex[i]})
    end
    remote(1'b0, NNP_INPUT, 16'h1234);
    `CHK({resolved_vld, resolved_num}, {1'b1, 17'h01234})
    $display("test offset resolve done");
  endtask
  task automatic t_mask;
    wr(`NNP_IDX_OUT_MASK, 32'h00ff);
    outs(1'b1, 16'h0000, 1'b0, 16'h0);
    outs(1'b0, 16'h0, 1'b1, 16'hffff);
    `CHK(out_state, 16'hff00)
    // extended numbering reaches a protected output
    remote(1'b1, NNP_OUTPUT, 16'h0003);
    `CHK(out_state, 16'hff08)
    outs(1'b1, 16'h0f0f, 1'b1, 16'hf0f0);
    `CHK(out_state, 16'h0f0f)
    $display("test output mask done");
  endtask
  task automatic t_target;
    logic [6:0] nv[3] = '{7'h00, 7'h01, 7'h7f};
    nnp_role_t er[3] = '{NNP_OFF, NNP_MASTER, NNP_SLAVE};
    wr(`NNP_IDX_INDIRECT_NODE, 32'h5);
    @(posedge mclk); instr_node <= 7'h00; @(posedge mclk); @(negedge mclk);
    `CHK(target_node, 7'h05)
    @(posedge mclk); instr_node <= 7'h09; @(posedge mclk); @(negedge mclk);
    `CHK(target_node, 7'h09)
    for (int i = 0; i < 3; i++) begin
      wr(`NNP_IDX_NODE_NUMBER, {25'h0, nv[i]});
      @(negedge mclk);
      `CHK(node_role, er[i])
    end
    $display("test target node done");
  endtask
  // read last error code and error count in one go
  task automatic stat_chk(output logic [31:0] e, output logic [31:0] c);
    rd(`NNP_IDX_LAST_ERROR, e);
    rd(`NNP_IDX_ERROR_COUNT, c);
  endtask
  task automatic nomaster;
    @(posedge mclk); net_no_master <= 1'b1; @(posedge mclk); net_no_master <= 1'b0;
  endtask
  task automatic t_track;
    logic [31:0] e, c, r;
    net(1'b0, 8'h00, NNP_OK, 30);
    stat_chk(e, c);
    `CHK({e, c}, {32'h1, 32'h1})
    wr(`NNP_IDX_TIMEOUT_MS, 32'hfa);
    net(1'b1, 8'h02, NNP_CKSUM, 6);
    stat_chk(e, c);
    `CHK({e, c}, {32'h2, 32'h2})
    net(1'b1, 8'h02, NNP_SLVERR, 6);
    stat_chk(e, c);
    `CHK({e, c}, {32'h3, 32'h3})
    net(1'b1, 8'd40, NNP_OK, 44);
    stat_chk(e, c);
    `CHK({e, c}, {32'h0, 32'h3})
    rd(`NNP_IDX_RESP_TIME_MS, r);
    `CHK(r >= 32'd9 && r <= 32'd11, 1'b1)
    nomaster;
    stat_chk(e, c);
    `CHK({e, c}, {32'h4, 32'h4})
    wr(`NNP_IDX_LAST_ERROR, 32'h0);
    wr(`NNP_IDX_ERROR_COUNT, 32'h0);
    wr(`NNP_IDX_RESP_TIME_MS, 32'h0);
    stat_chk(e, c);
    `CHK({e, c}, {32'h0, 32'h4})
    rd(`NNP_IDX_RESP_TIME_MS, e);
    `CHK(e, r)
    // count must stick at its top value
    repeat (260) nomaster;
    stat_chk(e, c);
    `CHK(c, 32'hff)
    $display("test access tracking done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_rw;
    t_resolve;
    t_mask;
    t_target;
    t_track;
    results;
  end
endmodule
`default_nettype wire
